// ===== verilog/csc_top.sv
// csc_top: charger timer/thermal fault control, boost mode selection,
// overload retry, battery overcurrent retry and temperature zone control
// assumes comparator inputs synchronous to clk_i except zone comparators
`timescale 1ns/1ps
`default_nettype none

// Operation
// - time prequal, fast and topoff stays; prequal or fast overrun faults
// - timer fault releases fault status output and turns charger off
// - timer fault exits only on charger input removal then reapplication
// - junction over shutdown threshold forces thermal shutdown except in timer fault, charger off
// - mode code 0x0A enables reverse boost to bypass and charger input
// - mode code 0x08 boosts bypass node only, input switch stays open
// - sink attach from port detection enables reverse boost automatically
// - source overload opens switch, retries after 300ms, then 60ms on/300ms off
// - discharge over 6A for qualify time opens battery switch, buck off
// - during overcurrent fault, low rail for retry time restarts power-up
// - rail below power-up threshold limits battery current to power-up limit
// - above regulation temperature cut target 5% per degree, zero at 20 degrees
// - thermistor pulled to ground disables charging
// - zone-control disable bit bypasses all temperature zone adjustments
// - cool zone cuts fast current to 50% or 20%, default 50%
// - warm zone lowers termination voltage by 150mV or 100mV
// - charging suspended below cold or above hot threshold
// - hot/cold-only bit skips warm and cool adjustments, keeps stops
module csc_top
   import csc_pkg::*;
#(
   parameter int unsigned TICK_CYC  = TICK_DIV,
   parameter int unsigned MIN_TICKS = MS_PER_MIN
)(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq_o,
   // charger state inputs
   input  wire logic        charger_input_valid_i,
   input  wire logic        battery_node_above_prequal_i,
   input  wire logic        battery_node_at_regulation_i,
   input  wire logic        battery_node_recharge_i,
   input  wire logic        term_current_i,
   input  wire logic        junction_shutdown_i,
   input  wire logic [7:0]  junction_over_reg_deg_i,
   input  wire logic        sink_attached_i,
   input  wire logic        source_overload_i,
   input  wire logic        battery_node_overcurrent_i,
   input  wire logic        system_rail_low_i,
   input  wire logic        thermistor_input_grounded_i,
   input  wire logic        below_cold_i,
   input  wire logic        below_cool_i,
   input  wire logic        above_warm_i,
   input  wire logic        above_hot_i,
   // controls
   output logic             fault_status_out_o,
   output logic             fault_status_out_oe_n_o,
   output logic             charger_on_o,
   output logic             boost_on_o,
   output logic             charger_input_switch_o,
   output logic             battery_switch_o,
   output logic             buck_on_o,
   output logic             powerup_limit_o,
   output logic [7:0]       charge_pct_o,
   output logic [7:0]       term_drop_mv_o
);
   // ---------------------------------------------------------------
   // millisecond tick
   // ---------------------------------------------------------------
   logic [31:0] div_r, div_nxt;
   logic        tick_r, tick_nxt;
   always_comb
   begin
      div_nxt  = div_r + 32'h1;
      tick_nxt = 1'b0;
      if (div_r >= TICK_CYC - 1)
      begin
         div_nxt  = 32'h0;
         tick_nxt = 1'b1;
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         div_r  <= 32'h0;
         tick_r <= 1'b0;
      end
      else
      begin
         div_r  <= div_nxt;
         tick_r <= tick_nxt;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0]       cfg_r, cfg_nxt, tcfg_r, tcfg_nxt;
   logic [IRQ_W-1:0] ist_r, ist_nxt, imsk_r, imsk_nxt, ev;
   logic [31:0]      rdat_nxt, dat_r;
   logic             ack_r, ack_nxt, irq_nxt, irq_r;
   logic             acc;
   logic [31:0]      status_w;
   logic [3:0]       mode;
   assign acc  = wb_cyc_i & wb_stb_i & ~ack_r;
   assign mode = cfg_r[MODE_LSB +: 4];

   always_comb
   begin
      cfg_nxt  = cfg_r;
      tcfg_nxt = tcfg_r;
      imsk_nxt = imsk_r;
      rdat_nxt = 32'h0;
      ist_nxt  = ist_r;
      if (acc && wb_we_i && wb_sel_i[0])
      begin
         case (wb_adr_i)
            ADDR_CFG_FIRST: cfg_nxt  = wb_dat_i[7:0];
            ADDR_TEMP_CFG:  tcfg_nxt = wb_dat_i[7:0];
            ADDR_IRQ_MASK:  imsk_nxt = wb_dat_i[IRQ_W-1:0];
            default:        ;
         endcase
      end
      if (acc && !wb_we_i)
      begin
         case (wb_adr_i)
            ADDR_CFG_FIRST: rdat_nxt = {24'h0, cfg_r};
            ADDR_TEMP_CFG:  rdat_nxt = {24'h0, tcfg_r};
            ADDR_STATUS:    rdat_nxt = status_w;
            ADDR_IRQ_STAT:
            begin
               rdat_nxt = {27'h0, ist_r};
               ist_nxt  = '0;
            end
            ADDR_IRQ_MASK:  rdat_nxt = {27'h0, imsk_r};
            ADDR_CURRENT:   rdat_nxt = {16'h0, term_drop_mv_o, charge_pct_o};
            default:        rdat_nxt = 32'h0;
         endcase
      end
      // new events win over read-clear
      ist_nxt = ist_nxt | ev;
      ack_nxt = acc;
      irq_nxt = |(ist_nxt & imsk_r);
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg_r  <= CFG_FIRST_RST;
         tcfg_r <= TEMP_CFG_RST;
         ist_r  <= '0;
         imsk_r <= '0;
         dat_r  <= 32'h0;
         ack_r  <= 1'b0;
         irq_r  <= 1'b0;
      end
      else
      begin
         cfg_r  <= cfg_nxt;
         tcfg_r <= tcfg_nxt;
         ist_r  <= ist_nxt;
         imsk_r <= imsk_nxt;
         dat_r  <= rdat_nxt;
         ack_r  <= ack_nxt;
         irq_r  <= irq_nxt;
      end
   end
   assign wb_dat_o = dat_r;
   assign wb_ack_o = ack_r;
   assign irq_o    = irq_r;

   // ---------------------------------------------------------------
   // zone comparator synchroniser and classification
   // ---------------------------------------------------------------
   logic [3:0] zs1_r, zs2_r;
   csc_zone_t  zone_r, zone_nxt;
   always_comb
   begin
      if (zs2_r[0])      zone_nxt = ZN_COLD;
      else if (zs2_r[3]) zone_nxt = ZN_HOT;
      else if (zs2_r[1]) zone_nxt = ZN_COOL;
      else if (zs2_r[2]) zone_nxt = ZN_WARM;
      else               zone_nxt = ZN_NORMAL;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         zs1_r  <= 4'h0;
         zs2_r  <= 4'h0;
         zone_r <= ZN_NORMAL;
      end
      else
      begin
         zs1_r  <= {above_hot_i, above_warm_i, below_cool_i, below_cold_i};
         zs2_r  <= zs1_r;
         zone_r <= zone_nxt;
      end
   end

   // ---------------------------------------------------------------
   // charge state and safety timer
   // ---------------------------------------------------------------
   csc_chg_t    cs_r, cs_nxt;
   logic [31:0] tmr_r, tmr_nxt;
   logic        vin_d_r;
   logic        suspend;
   always_comb
   begin
      cs_nxt  = cs_r;
      tmr_nxt = tick_r ? tmr_r + 32'h1 : tmr_r;
      case (cs_r)
         CS_IDLE:
            if (charger_input_valid_i)
            begin
               cs_nxt  = battery_node_above_prequal_i ? CS_FAST : CS_PREQ;
               tmr_nxt = 32'h0;
            end
         CS_PREQ:
            if (battery_node_above_prequal_i)
            begin
               cs_nxt  = CS_FAST;
               tmr_nxt = 32'h0;
            end
            else if (tmr_r >= PREQUAL_MIN * MIN_TICKS)
               cs_nxt = CS_TFAULT;
         CS_FAST:
            if (tmr_r >= FASTCHG_MIN * MIN_TICKS)
               cs_nxt = CS_TFAULT;
            else if (battery_node_at_regulation_i && term_current_i)
            begin
               cs_nxt  = CS_TOPOFF;
               tmr_nxt = 32'h0;
            end
         CS_TOPOFF:
            if (battery_node_recharge_i)
            begin
               cs_nxt  = CS_FAST;
               tmr_nxt = 32'h0;
            end
            else if (tmr_r >= TOPOFF_MIN * MIN_TICKS)
               cs_nxt = CS_DONE;
         CS_DONE:
            if (battery_node_recharge_i)
            begin
               cs_nxt  = CS_FAST;
               tmr_nxt = 32'h0;
            end
         CS_TFAULT:  ;
         CS_SHUTDOWN_TEMPERATURE:
            if (!junction_shutdown_i)
               cs_nxt = CS_IDLE;
         default:    cs_nxt = CS_IDLE;
      endcase
      // removal then reinsertion restarts from idle
      if (!charger_input_valid_i)
         cs_nxt = CS_IDLE;
      if (junction_shutdown_i && charger_input_valid_i && cs_r != CS_TFAULT)
         cs_nxt = CS_SHUTDOWN_TEMPERATURE;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cs_r    <= CS_IDLE;
         tmr_r   <= 32'h0;
         vin_d_r <= 1'b0;
      end
      else
      begin
         cs_r    <= cs_nxt;
         tmr_r   <= tmr_nxt;
         vin_d_r <= charger_input_valid_i;
      end
   end

   // ---------------------------------------------------------------
   // source-role overload retry
   // ---------------------------------------------------------------
   csc_ovl_t    ov_r, ov_nxt;
   logic [15:0] ovt_r, ovt_nxt;
   logic        boost_req, rev_req;
   assign rev_req   = (mode == MODE_REV_BOOST) | sink_attached_i;
   assign boost_req = rev_req | (mode == MODE_BYP_BOOST);
   always_comb
   begin
      ov_nxt  = ov_r;
      ovt_nxt = tick_r ? ovt_r + 16'h1 : ovt_r;
      case (ov_r)
         OV_ON:
            if (rev_req && source_overload_i)
            begin
               ov_nxt  = OV_OFF;
               ovt_nxt = 16'h0;
            end
         OV_OFF:
            if (ovt_r >= 16'(RETRY_OFF_MS))
            begin
               ov_nxt  = OV_RETRY;
               ovt_nxt = 16'h0;
            end
         OV_RETRY:
            if (source_overload_i && ovt_r >= 16'(RETRY_ON_MS))
            begin
               ov_nxt  = OV_OFF;
               ovt_nxt = 16'h0;
            end
            else if (!source_overload_i)
               ov_nxt = OV_ON;
         default: ov_nxt = OV_ON;
      endcase
      if (!rev_req)
         ov_nxt = OV_ON;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ov_r  <= OV_ON;
         ovt_r <= 16'h0;
      end
      else
      begin
         ov_r  <= ov_nxt;
         ovt_r <= ovt_nxt;
      end
   end

   // ---------------------------------------------------------------
   // battery overcurrent fault and retry
   // ---------------------------------------------------------------
   csc_bovc_t   bo_r, bo_nxt;
   logic [31:0] bot_r, bot_nxt;
   always_comb
   begin
      bo_nxt  = bo_r;
      bot_nxt = bot_r;
      case (bo_r)
         BO_RUN:
         begin
            bot_nxt = battery_node_overcurrent_i ? bot_r + 32'h1 : 32'h0;
            if (battery_node_overcurrent_i && bot_r >= OVC_QUAL_CYC - 1)
            begin
               bo_nxt  = BO_FAULT;
               bot_nxt = 32'h0;
            end
         end
         BO_FAULT:
         begin
            // rail must stay low for the whole retry window
            bot_nxt = !system_rail_low_i ? 32'h0 : (tick_r ? bot_r + 32'h1 : bot_r);
            if (system_rail_low_i && bot_r >= OCP_RETRY_MS)
            begin
               bo_nxt  = BO_RUN;
               bot_nxt = 32'h0;
            end
         end
         default:
         begin
            bo_nxt  = BO_RUN;
            bot_nxt = 32'h0;
         end
      endcase
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         bo_r  <= BO_RUN;
         bot_r <= 32'h0;
      end
      else
      begin
         bo_r  <= bo_nxt;
         bot_r <= bot_nxt;
      end
   end

   // ---------------------------------------------------------------
   // output shaping
   // ---------------------------------------------------------------
   logic       zone_dis, hc_only, chg_on_nxt, tfault;
   logic [7:0] fold, pct_nxt, drop_nxt, base_pct;
   assign zone_dis = cfg_r[ZONE_DIS_BIT];
   assign hc_only  = tcfg_r[HOTCOLD_ONLY_BIT];
   assign tfault   = (cs_r == CS_TFAULT);
   always_comb
   begin
      suspend = !zone_dis && (zone_r == ZN_COLD || zone_r == ZN_HOT);
      chg_on_nxt = (cs_r == CS_PREQ || cs_r == CS_FAST || cs_r == CS_TOPOFF)
                   && !thermistor_input_grounded_i && !suspend && !boost_req
                   && (bo_r == BO_RUN);
      base_pct = PCT_FULL;
      drop_nxt = 8'h0;
      if (!zone_dis && !hc_only && zone_r == ZN_COOL)
         base_pct = (tcfg_r[COOL_SEL_LSB +: 2] == COOL_SEL_HALF) ? PCT_HALF : PCT_FIFTH;
      if (!zone_dis && !hc_only && zone_r == ZN_WARM)
         drop_nxt = (tcfg_r[WARM_SEL_LSB +: 2] == 2'h0) ? WARM_DROP_150 : WARM_DROP_100;
      if (junction_over_reg_deg_i >= FOLD_ZERO_DEG)
         fold = PCT_FULL;
      else
         fold = 8'(junction_over_reg_deg_i * FOLD_PCT_PER_DEG);
      pct_nxt = (fold >= base_pct) ? 8'h0 : 8'(base_pct - fold);
      if (!chg_on_nxt)
         pct_nxt = 8'h0;
      ev = '0;
      ev[IRQ_TIMER] = (cs_nxt == CS_TFAULT) && !tfault;
      ev[IRQ_SHUTDOWN_TEMPERATURE] = (cs_nxt == CS_SHUTDOWN_TEMPERATURE) && (cs_r != CS_SHUTDOWN_TEMPERATURE);
      ev[IRQ_OVLD]  = (ov_nxt == OV_OFF) && (ov_r != OV_OFF);
      ev[IRQ_BOVC]  = (bo_nxt == BO_FAULT) && (bo_r != BO_FAULT);
      ev[IRQ_ZONE]  = (zone_nxt != zone_r);
   end
   assign status_w = {24'h0, 1'b0, zone_r, vin_d_r, tfault, bo_r == BO_FAULT, ov_r != OV_ON};
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         fault_status_out_o      <= 1'b0;
         fault_status_out_oe_n_o <= 1'b1;
         charger_on_o            <= 1'b0;
         boost_on_o              <= 1'b0;
         charger_input_switch_o  <= 1'b0;
         battery_switch_o        <= 1'b1;
         buck_on_o               <= 1'b0;
         powerup_limit_o         <= 1'b1;
         charge_pct_o            <= 8'h0;
         term_drop_mv_o          <= 8'h0;
      end
      else
      begin
         fault_status_out_o      <= 1'b0;
         fault_status_out_oe_n_o <= tfault;
         charger_on_o            <= chg_on_nxt;
         boost_on_o              <= boost_req && (bo_r == BO_RUN);
         charger_input_switch_o  <= rev_req && (ov_r != OV_OFF) && (bo_r == BO_RUN);
         battery_switch_o        <= (bo_r == BO_RUN);
         buck_on_o               <= (bo_r == BO_RUN) && !boost_req;
         powerup_limit_o         <= system_rail_low_i;
         charge_pct_o            <= pct_nxt;
         term_drop_mv_o          <= drop_nxt;
      end
   end
endmodule
`default_nettype wire

// ===== verilog/csc_pkg.sv
// csc_pkg: constants for the charger safety control block
// assumes a 200 MHz logic clock and a classic wishbone register port
package csc_pkg;
   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ           = 200_000_000;
   localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;
   localparam int unsigned RETRY_OFF_MS     = 300;
   localparam int unsigned RETRY_ON_MS      = 60;
   localparam int unsigned PREQUAL_MIN      = 30;
   localparam int unsigned FASTCHG_MIN      = 300;
   localparam int unsigned TOPOFF_MIN       = 30;
   localparam int unsigned OVC_QUAL_US      = 16;
   localparam int unsigned OCP_RETRY_MS     = 150;
   localparam int unsigned TICK_DIV         = CYC_PER_MS;
   localparam int unsigned OVC_QUAL_CYC     = OVC_QUAL_US * (CLK_HZ / 1_000_000);
   localparam int unsigned MS_PER_MIN       = 60_000;

   // ---------------------------------------------------------------
   // register map (byte offsets)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CFG_FIRST    = 8'h00;
   localparam logic [7:0] ADDR_TEMP_CFG     = 8'h04;
   localparam logic [7:0] ADDR_STATUS       = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STAT     = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_MASK     = 8'h10;
   localparam logic [7:0] ADDR_CURRENT      = 8'h14;

   // ---------------------------------------------------------------
   // fields
   // ---------------------------------------------------------------
   localparam int unsigned MODE_LSB         = 0;
   localparam int unsigned ZONE_DIS_BIT     = 5;
   localparam int unsigned COOL_SEL_LSB     = 3;
   localparam int unsigned WARM_SEL_LSB     = 5;
   localparam int unsigned HOTCOLD_ONLY_BIT = 7;
   localparam logic [3:0] MODE_REV_BOOST    = 4'hA;
   localparam logic [3:0] MODE_BYP_BOOST    = 4'h8;
   localparam logic [7:0] CFG_FIRST_RST     = 8'h05;
   localparam logic [7:0] TEMP_CFG_RST      = 8'h00;
   localparam logic [1:0] COOL_SEL_HALF     = 2'h0;
   localparam logic [7:0] FOLD_PCT_PER_DEG  = 8'h05;
   localparam logic [7:0] FOLD_ZERO_DEG     = 8'h14;
   localparam logic [7:0] PCT_FULL          = 8'h64;
   localparam logic [7:0] PCT_HALF          = 8'h32;
   localparam logic [7:0] PCT_FIFTH         = 8'h14;
   localparam logic [7:0] WARM_DROP_150     = 8'h96;
   localparam logic [7:0] WARM_DROP_100     = 8'h64;

   // interrupt bits
   localparam int unsigned IRQ_TIMER        = 0;
   localparam int unsigned IRQ_SHUTDOWN_TEMPERATURE        = 1;
   localparam int unsigned IRQ_OVLD         = 2;
   localparam int unsigned IRQ_BOVC         = 3;
   localparam int unsigned IRQ_ZONE         = 4;
   localparam int unsigned IRQ_W            = 5;

   typedef enum logic [2:0] {ZN_COLD, ZN_COOL, ZN_NORMAL, ZN_WARM, ZN_HOT} csc_zone_t;
   typedef enum {CS_IDLE, CS_PREQ, CS_FAST, CS_TOPOFF, CS_DONE, CS_TFAULT, CS_SHUTDOWN_TEMPERATURE} csc_chg_t;
   typedef enum {OV_ON, OV_OFF, OV_RETRY} csc_ovl_t;
   typedef enum {BO_RUN, BO_FAULT, BO_WAIT} csc_bovc_t;
endpackage

// ===== dv/csc_top_asserts.sv
// csc_top_asserts: port checks for the charger safety block
// assumes the csc_top port names; bound at the foot
`timescale 1ns/1ps
`default_nettype none
module csc_top_asserts
(
   // clock, reset, bus
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   // pins
   input wire logic       junction_shutdown_i,
   input wire logic [7:0] junction_over_reg_deg_i,
   input wire logic       sink_attached_i,
   input wire logic       battery_node_overcurrent_i,
   input wire logic       system_rail_low_i,
   input wire logic       thermistor_input_grounded_i,
   input wire logic       fault_status_out_o,
   input wire logic       fault_status_out_oe_n_o,
   input wire logic       charger_on_o,
   input wire logic       boost_on_o,
   input wire logic       charger_input_switch_o,
   input wire logic       battery_switch_o,
   input wire logic       buck_on_o,
   input wire logic       powerup_limit_o,
   input wire logic [7:0] charge_pct_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack one cycle after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   fault_release_a: assert property (
      fault_status_out_oe_n_o |-> !charger_on_o && !fault_status_out_o)
      else $error("released fault pin with charger on");
   shutdown_temperature_off_a: assert property (
      junction_shutdown_i [*3] |-> !charger_on_o) else $error("charger on in shutdown");
   thm_off_a: assert property (
      thermistor_input_grounded_i [*3] |-> !charger_on_o) else $error("charger on, pin low");
   sink_boost_a: assert property (
      sink_attached_i [*3] |-> boost_on_o) else $error("no boost with sink");
   switch_boost_a: assert property (
      !boost_on_o |-> !charger_input_switch_o) else $error("input switch without boost");
   oc_trip_a: assert property (
      $fell(battery_switch_o) |-> $past(battery_node_overcurrent_i) ##1 !buck_on_o)
      else $error("battery switch opened without cause");
   pu_limit_a: assert property (
      system_rail_low_i [*3] |-> powerup_limit_o) else $error("no power-up limit");
   fold_zero_a: assert property (
      (junction_over_reg_deg_i >= 8'h14) [*5] |-> charge_pct_o == 8'h00)
      else $error("current not zero at full foldback");
endmodule
bind csc_top csc_top_asserts u_chk (.*);
`default_nettype wire

// ===== dv/csc_mcu_model.sv
// csc_mcu_model: classic wishbone master for the system controller
// assumes the slave shares clk_i; callers enter xfer after a rising edge
`timescale 1ns/1ps
`default_nettype none
module csc_mcu_model
(
   // clock
   input  wire logic        clk_i,
   // wishbone master
   output var logic         cyc_o = 1'b0,
   output var logic         stb_o = 1'b0,
   output var logic         we_o = 1'b0,
   output var logic [7:0]   adr_o = 8'h00,
   output var logic [31:0]  dat_o = 32'h0,
   output var logic [3:0]   sel_o = 4'h0,
   input  wire logic [31:0] dat_i,
   input  wire logic        ack_i
);
   // request held until ack is seen at an edge; no fixed latency assumed
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      dat_o <= d;
      sel_o <= 4'hF;
      do
         @(posedge clk_i);
      while (ack_i !== 1'b1);
      q = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// ===== dv/csc_top_tb.sv
// csc_top_tb: self-checking bench for the charger safety block
// assumes a 10-cycle tick so the retry windows stay short
`timescale 1ns/1ps
`default_nettype none
module csc_top_tb;
   import csc_pkg::*;
   localparam int TICK = 10;
   logic clk_i = 1'b0, rst_i = 1'b1, tie0 = 1'b0;
   logic vld = 0, shd = 0, sink = 0, ovl = 0, boc = 0, rail = 0, thermistor_input = 0;
   logic cold = 0, cool = 0, warm = 0, hot = 0, cyc, stb, we, ack, irq;
   logic fs, fs_oe_n, chg_on, boost, sw, bsw, buck, pul;
   logic [7:0] adr, pct, drop, deg = 8'h00;
   logic [31:0] wdat, rdat;
   logic [3:0] sel;
   int fail_count = 0, checked = 0, cyc_n = 0;
   integer seed = 32'hf1b10a02;
   logic [3:0] mcode [3] = '{MODE_REV_BOOST, MODE_BYP_BOOST, 4'h0};
   logic [7:0] tcs [$] = '{8'h00, 8'h08, 8'h20, 8'h80};

   csc_mcu_model u_mcu (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
      .dat_o(wdat), .sel_o(sel), .dat_i(rdat), .ack_i(ack));
   csc_top #(.TICK_CYC(TICK), .MIN_TICKS(30)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
      .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .charger_input_valid_i(vld),
      .battery_node_above_prequal_i(tie0), .battery_node_at_regulation_i(tie0), .battery_node_recharge_i(tie0),
      .term_current_i(tie0), .junction_shutdown_i(shd), .junction_over_reg_deg_i(deg),
      .sink_attached_i(sink), .source_overload_i(ovl), .battery_node_overcurrent_i(boc),
      .system_rail_low_i(rail), .thermistor_input_grounded_i(thermistor_input), .below_cold_i(cold),
      .below_cool_i(cool), .above_warm_i(warm), .above_hot_i(hot),
      .fault_status_out_o(fs), .fault_status_out_oe_n_o(fs_oe_n), .charger_on_o(chg_on),
      .boost_on_o(boost), .charger_input_switch_o(sw), .battery_switch_o(bsw),
      .buck_on_o(buck), .powerup_limit_o(pul), .charge_pct_o(pct), .term_drop_mv_o(drop));

   initial
   begin
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 30000)
      begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input int e, input logic [31:0] s);
      checked++;
      if (s !== 32'(e))
      begin
         fail_count++;
         $display("mismatch %s expected %0h seen %0h", n, e, s);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic [31:0] q;
      u_mcu.xfer(1'b1, a, {24'($random(seed)), v}, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      u_mcu.xfer(1'b0, a, 32'h0, q);
   endtask
   // bounded wait, n counts the edges passed
   task automatic span(ref logic s, input logic v, input int lim, output int n);
      n = 0;
      while (s !== v && n < lim)
      begin
         @(posedge clk_i);
         n++;
      end
   endtask
   task automatic zone(input int z);
      cold <= (z == 0);
      cool <= (z <= 1);
      warm <= (z >= 3);
      hot <= (z == 4);
      tick(8);
   endtask
   // reference model of the current target and termination drop
   function automatic int exp_pct(int z, logic [7:0] c0, logic [7:0] tc, int d);
      int p;
      p = (d >= 20) ? 0 : 100 - 5 * d;
      if (c0[ZONE_DIS_BIT])
         return p;
      if (z == 0 || z == 4)
         return 0;
      if (tc[HOTCOLD_ONLY_BIT] || z != 1)
         return p;
      return (tc[4:3] == COOL_SEL_HALF) ? 50 : 20;
   endfunction
   function automatic int exp_drop(int z, logic [7:0] c0, logic [7:0] tc);
      if (c0[ZONE_DIS_BIT] || tc[HOTCOLD_ONLY_BIT] || z != 3)
         return 0;
      return (tc[6:5] == 2'h0) ? 150 : 100;
   endfunction

   initial
   begin
      logic [31:0] q;
      logic [7:0] c0;
      int n;
      int d;
      tick(5);
      rst_i <= 1'b0;
      tick(2);
      vld <= 1'b1;
      zone(2);
      rd(ADDR_CFG_FIRST, q);
      chk("cfg_rst", CFG_FIRST_RST, q[7:0]);
      rd(8'h3C, q);
      chk("unmapped", 0, q);
      for (int i = 0; i < 3; i++)
      begin
         wr(ADDR_CFG_FIRST, {4'h0, mcode[i]});
         tick(3);
         chk("boost", mcode[i] != 4'h0, boost);
         chk("in_switch", mcode[i] == MODE_REV_BOOST, sw);
      end
      sink <= 1'b1;
      wr(ADDR_IRQ_MASK, 8'h04);
      tick(3);
      chk("sink_sw", 1, sw);
      ovl <= 1'b1;
      span(sw, 1'b0, 50, n);
      tick(3);
      chk("ovl_irq", 1, irq);
      rd(ADDR_IRQ_STAT, q);
      chk("ovl_stat", 1, q[IRQ_OVLD]);
      span(sw, 1'b1, 4000, n);
      chk("off_time", 1, n >= 2960 && n <= 3020);
      span(sw, 1'b0, 1000, n);
      chk("on_time", 1, n >= 585 && n <= 615);
      ovl <= 1'b0;
      sink <= 1'b0;
      wr(ADDR_IRQ_MASK, 8'h00);
      shd <= 1'b1;
      tick(4);
      chk("shutdown_temperature_on", 0, chg_on);
      chk("masked", 0, irq);
      shd <= 1'b0;
      wr(ADDR_IRQ_MASK, 8'h02);
      tick(2);
      chk("irq_set", 1, irq);
      rd(ADDR_IRQ_STAT, q);
      chk("stat_set", 1, q[IRQ_SHUTDOWN_TEMPERATURE]);
      tick(2);
      chk("irq_clr", 0, irq);
      rd(ADDR_IRQ_STAT, q);
      chk("stat_clr", 0, q[IRQ_SHUTDOWN_TEMPERATURE]);
      thermistor_input <= 1'b1;
      tick(5);
      chk("thm_on", 0, chg_on);
      thermistor_input <= 1'b0;
      for (int k = 0; k < 8; k++)
      begin
         c0 = (k >= 4) ? 8'h20 : 8'h00;
         wr(ADDR_CFG_FIRST, c0);
         wr(ADDR_TEMP_CFG, tcs[k % 4]);
         for (int z = 0; z < 5; z++)
         begin
            zone(z);
            chk("pct", exp_pct(z, c0, tcs[k % 4], 0), pct);
            chk("drop", exp_drop(z, c0, tcs[k % 4]), drop);
            rd(ADDR_STATUS, q);
            chk("zone", z, q[6:4]);
         end
      end
      zone(2);
      for (int i = 0; i < 12; i++)
      begin
         d = (i == 0) ? 20 : {$random(seed)} % 30;
         deg <= 8'(d);
         tick(6);
         chk("fold", exp_pct(2, 8'h00, 8'h00, d), pct);
      end
      deg <= 8'h00;
      boc <= 1'b1;
      span(bsw, 1'b0, 4000, n);
      chk("oc_qual", 1, n >= 3190 && n <= 3215);
      tick(2);
      chk("buck", 0, buck);
      rail <= 1'b1;
      tick(3);
      chk("pu_limit", 1, pul);
      span(bsw, 1'b1, 2500, n);
      chk("oc_retry", 1, n >= 1460 && n <= 1530);
      boc <= 1'b0;
      rail <= 1'b0;
      vld <= 1'b0;
      tick(4);
      vld <= 1'b1;
      span(fs_oe_n, 1'b1, 9100, n);
      chk("pq_time", 1, n >= 8980 && n <= 9020);
      chk("tf_on", 0, chg_on);
      shd <= 1'b1;
      tick(9);
      chk("tf_hold", 1, fs_oe_n);
      shd <= 1'b0;
      vld <= 1'b0;
      tick(4);
      chk("tf_exit", 0, fs_oe_n);
      wrap_up();
   end
endmodule
`default_nettype wire
